// ---- design/cli_interp.sv ----
// command list interpreter: fetch, execute, software register port
//
// The implementer's own choices: the address-and-strobe port and the address map.
`timescale 1ns/1ps
`include "cli_defines.svh"
module cli_interp
  import cli_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // software register port
  input wire logic [7:0] sw_addr_in,
  input wire logic [31:0] sw_wdata_in,
  input wire logic sw_wr_in,
  input wire logic sw_rd_in,
  output logic [31:0] sw_rdata_out,
  // host_side_bus master toward memory and registers
  output cli_bus_req_type bus_req_out,
  input cli_bus_rsp_type bus_rsp_in,
  // engine and display status
  input wire logic [20:0] hw_status_in,
  // finish interrupt
  output logic irq_out
);

  cli_state_type state;
  logic [1:0] idx;
  logic [31:0] cmd0;
  logic [31:0] cmd1;
  logic [31:0] cmd2;
  logic [27:0] pc;
  logic [27:0] ret_addr;
  logic [31:0] cond;
  logic [31:0] src;
  logic [31:0] dst;
  logic [31:0] cnt;
  logic start;
  logic istat;
  logic imask;
  logic [3:0] op;
  logic finish_now;
  logic status_match;
  logic addr_wr;

  function automatic logic is_wide(input logic [3:0] code);
    return (code == `CLI_OP_CPMEM) || (code == `CLI_OP_CPREG);
  endfunction

  function automatic logic [27:0] cmd_step(input logic [3:0] code);
    return is_wide(code) ? `CLI_WIDE_STEP : `CLI_CMD_STEP;
  endfunction

  // 28-bit sum wraps on its own
  function automatic logic [27:0] jump_target(input logic rel, input logic [27:0] base,
                                              input logic [27:0] field);
    logic [27:0] raw;
    raw = rel ? base + field : field;
    return raw & `CLI_PC_ALIGN;
  endfunction

  assign op = cmd0[31:28];
  assign addr_wr = sw_wr_in && (sw_addr_in == `CLI_REG_ADDR);
  assign finish_now = (state == st_exec) && (op == `CLI_OP_FINISH);
  // bits compared raw: each source keeps its own polarity (empty, busy, active, even all read 1)
  assign status_match = ((hw_status_in ^ cmd1[20:0]) & cmd0[20:0]) == 21'h000000;
  assign irq_out = istat && imask;

  // start bit: a software write wins over the finish clear
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      start <= 1'b0;
    end else if (addr_wr) begin
      start <= sw_wdata_in[`CLI_START_BIT];
    end else if (finish_now) begin
      start <= 1'b0;
    end
  end

  // finish interrupt status, write one to clear, set wins
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      istat <= 1'b0;
      imask <= 1'b0;
    end else begin
      if (finish_now && cmd0[0]) begin
        istat <= 1'b1;
      end else if (sw_wr_in && (sw_addr_in == `CLI_REG_ISTAT) && sw_wdata_in[0]) begin
        istat <= 1'b0;
      end
      if (sw_wr_in && (sw_addr_in == `CLI_REG_IMASK)) begin
        imask <= sw_wdata_in[0];
      end
    end
  end

  // condition bits belong to software alone
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cond <= 32'h00000000;
    end else if (sw_wr_in && (sw_addr_in == `CLI_REG_COND)) begin
      cond <= sw_wdata_in;
    end
  end

  // read data, valid only in the cycle after the strobe
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      sw_rdata_out <= 32'h00000000;
    end else if (!sw_rd_in) begin
      sw_rdata_out <= 32'h00000000;
    end else if (sw_addr_in == `CLI_REG_ADDR) begin
      sw_rdata_out <= {start, state == st_idle, 2'h0, pc};
    end else if (sw_addr_in == `CLI_REG_COND) begin
      sw_rdata_out <= cond;
    end else if (sw_addr_in == `CLI_REG_RET) begin
      sw_rdata_out <= {4'h0, ret_addr};
    end else if (sw_addr_in == `CLI_REG_ISTAT) begin
      sw_rdata_out <= {31'h00000000, istat};
    end else if (sw_addr_in == `CLI_REG_IMASK) begin
      sw_rdata_out <= {31'h00000000, imask};
    end else begin
      sw_rdata_out <= 32'h00000000;
    end
  end

  // sequencer and bus master
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      state <= st_idle;
      idx <= 2'h0;
      cmd0 <= 32'h00000000;
      cmd1 <= 32'h00000000;
      cmd2 <= 32'h00000000;
      pc <= 28'h0000000;
      ret_addr <= 28'h0000000;
      src <= 32'h00000000;
      dst <= 32'h00000000;
      cnt <= 32'h00000000;
      bus_req_out <= '0;
    end else begin
      case (state)
        st_idle: begin
          // address only taken while stopped; a running list keeps its own counter
          if (addr_wr) begin
            pc <= sw_wdata_in[27:0] & `CLI_PC_ALIGN;
          end else if (start) begin
            state <= st_fetch;
            idx <= 2'h0;
            bus_req_out.rd <= 1'b1;
            bus_req_out.reg_space <= 1'b0;
            bus_req_out.addr <= {4'h0, pc};
          end
        end
        st_fetch: begin
          if (bus_rsp_in.ack) begin
            if (idx == 2'h0) begin
              cmd0 <= bus_rsp_in.rdata;
            end else if (idx == 2'h1) begin
              cmd1 <= bus_rsp_in.rdata;
            end else if (idx == 2'h2) begin
              cmd2 <= bus_rsp_in.rdata;
            end
            idx <= idx + 2'h1;
            bus_req_out.addr <= bus_req_out.addr + `CLI_WORD_STEP;
            if ((idx == 2'h1 && !is_wide(op)) || idx == 2'h3) begin
              bus_req_out.rd <= 1'b0;
              state <= st_exec;
            end
          end
        end
        st_exec: begin
          state <= st_next;
          case (op)
            `CLI_OP_LDMEM, `CLI_OP_LDREG: begin
              cnt <= 32'h00000001;
              bus_req_out.wr <= 1'b1;
              bus_req_out.reg_space <= (op == `CLI_OP_LDREG);
              // opcode and width bits stay off the target address
              bus_req_out.addr <= cmd0 & ((op == `CLI_OP_LDREG) ? `CLI_REG_SPACE : `CLI_MEM_ALIGN);
              bus_req_out.wdata <= cmd1;
              state <= st_write;
            end
            `CLI_OP_CPMEM, `CLI_OP_CPREG: begin
              src <= cmd2 & {4'h0, 28'hffffffc};
              dst <= cmd0 & {4'h0, 28'hffffffc};
              cnt <= cmd1;
              if (cmd1 == 32'h00000000) begin
                pc <= pc + cmd_step(op);
              end else begin
                bus_req_out.rd <= 1'b1;
                bus_req_out.reg_space <= 1'b0;
                bus_req_out.addr <= cmd2 & {4'h0, 28'hffffffc};
                state <= st_read;
              end
            end
            `CLI_OP_STAT: begin
              state <= st_wait;
            end
            `CLI_OP_FINISH: begin
              state <= st_idle;
            end
            `CLI_OP_GOTO: begin
              pc <= jump_target(cmd1[0], pc, cmd0[27:0]);
            end
            `CLI_OP_GOSUB: begin
              ret_addr <= pc + `CLI_CMD_STEP;
              pc <= jump_target(cmd1[0], pc, cmd0[27:0]);
            end
            `CLI_OP_RET: begin
              pc <= ret_addr;
            end
            `CLI_OP_CJMP: begin
              if ((cmd1 & cond) != 32'h00000000) begin
                pc <= jump_target(1'b1, pc + `CLI_CMD_STEP, cmd0[27:0]);
              end else begin
                pc <= pc + `CLI_CMD_STEP;
              end
            end
            default: begin
              pc <= pc + `CLI_CMD_STEP;
            end
          endcase
        end
        st_read: begin
          if (bus_rsp_in.ack) begin
            bus_req_out.rd <= 1'b0;
            bus_req_out.wr <= 1'b1;
            bus_req_out.reg_space <= (op == `CLI_OP_CPREG);
            bus_req_out.addr <= (op == `CLI_OP_CPREG) ? (dst & `CLI_REG_SPACE) : dst;
            bus_req_out.wdata <= bus_rsp_in.rdata;
            src <= src + `CLI_WORD_STEP;
            state <= st_write;
          end
        end
        st_write: begin
          if (bus_rsp_in.ack) begin
            bus_req_out.wr <= 1'b0;
            dst <= dst + `CLI_WORD_STEP;
            cnt <= cnt - 32'h00000001;
            if (cnt == 32'h00000001) begin
              pc <= pc + cmd_step(op);
              state <= st_next;
            end else begin
              bus_req_out.rd <= 1'b1;
              bus_req_out.reg_space <= 1'b0;
              bus_req_out.addr <= src;
              state <= st_read;
            end
          end
        end
        st_wait: begin
          // a stop during the wait leaves the counter on the test so it reruns
          if (!start) begin
            state <= st_idle;
          end else if (status_match) begin
            pc <= pc + `CLI_CMD_STEP;
            state <= st_next;
          end
        end
        st_next: begin
          if (start) begin
            state <= st_fetch;
            idx <= 2'h0;
            bus_req_out.rd <= 1'b1;
            bus_req_out.reg_space <= 1'b0;
            bus_req_out.addr <= {4'h0, pc};
          end else begin
            state <= st_idle;
          end
        end
        default: begin
          state <= st_idle;
        end
      endcase
    end
  end

  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);

  finish_stop_a: assert property (finish_now && !addr_wr |=> !start && state == st_idle)
    else $error("finish did not stop the list");
  irq_cause_a: assert property ($rose(istat) |-> $past(finish_now && cmd0[0]))
    else $error("interrupt flag set without finish");
  irq_gate_a: assert property (finish_now && cmd0[0] && imask |=> irq_out)
    else $error("unmasked finish raised no interrupt");
  goto_abs_a: assert property (state == st_exec && op == `CLI_OP_GOTO && !cmd1[0]
    |=> pc == ($past(cmd0[27:0]) & 28'hffffff8))
    else $error("absolute goto target wrong");
  gosub_save_a: assert property (state == st_exec && op == `CLI_OP_GOSUB
    |=> ret_addr == $past(pc) + 28'h0000008)
    else $error("gosub saved wrong return address");
  return_a: assert property (state == st_exec && op == `CLI_OP_RET |=> pc == $past(ret_addr))
    else $error("return went elsewhere");
  cjmp_fall_a: assert property (state == st_exec && op == `CLI_OP_CJMP && (cmd1 & cond) == 32'h00000000
    |=> pc == $past(pc) + 28'h0000008)
    else $error("untaken jump left sequence");
  stat_hold_a: assert property (state == st_wait && start && !status_match |=> state == st_wait)
    else $error("status test left before match");
  stop_next_a: assert property (state == st_next && !start
    |=> state == st_idle ##1 ($stable(pc) || $past(addr_wr)))
    else $error("stop did not halt");
  idle_bit_a: assert property (sw_rd_in && sw_addr_in == `CLI_REG_ADDR
    |=> sw_rdata_out[30] == $past(state == st_idle))
    else $error("idle bit wrong");
  reg_space_a: assert property (bus_req_out.wr && bus_req_out.reg_space
    |-> bus_req_out.addr <= 32'h001ffffc && bus_req_out.addr[1:0] == 2'h0)
    else $error("register write outside space");
  cond_sw_a: assert property (!(sw_wr_in && sw_addr_in == `CLI_REG_COND) |=> $stable(cond))
    else $error("condition changed by hardware");

  finish_irq_c: cover property (finish_now && cmd0[0] ##1 irq_out);
  copy_done_c: cover property (state == st_write && bus_rsp_in.ack && cnt == 32'h00000001);
  gosub_ret_c: cover property (state == st_exec && op == `CLI_OP_GOSUB ##[1:200] state == st_exec && op == `CLI_OP_RET);
  wait_met_c: cover property (state == st_wait && !status_match ##1 status_match);

endmodule

// ---- common/cli_defines.svh ----
// offsets, field positions and opcodes of the command list interpreter
// Operation
// - memory indirect copy moves count words source to destination, source low bits zero
// - register indirect copy moves count words from memory into consecutive registers
// - register and destination addresses of indirect loads are word aligned
// - status test stalls until masked status equals masked expected bit values
// - command fifo status bits read one when empty
// - setup and drawing engine status bits read one while busy
// - vertical sync status bits read one while sync is active
// - current field bit reads zero for odd field, one for even
// - finish stops fetching and clears the start bit
// - finish with interrupt bit sets status flag and raises masked interrupt
// - goto jumps absolute, or relative to current command when relative bit set
// - jump targets have their three low bits forced to zero
// - gosub saves next command address, then jumps absolute or relative
// - return continues at the saved return address
// - conditional jump adds signed offset to next address when mask hits condition
// - clearing start halts after current command, address points at next command; a waiting status test halts at once, address on the test
// - idle flag in bit 30 of address register, one when idle
`ifndef CLI_DEFINES_SVH
`define CLI_DEFINES_SVH
`define CLI_REG_ADDR 8'h18
`define CLI_REG_COND 8'h1c
`define CLI_REG_RET 8'h20
`define CLI_REG_ISTAT 8'h24
`define CLI_REG_IMASK 8'h28
`define CLI_START_BIT 31
`define CLI_IDLE_BIT 30
`define CLI_OP_LDMEM 4'h0
`define CLI_OP_LDREG 4'h1
`define CLI_OP_CPMEM 4'h4
`define CLI_OP_CPREG 4'h5
`define CLI_OP_STAT 4'h6
`define CLI_OP_FINISH 4'h8
`define CLI_OP_GOTO 4'h9
`define CLI_OP_GOSUB 4'ha
`define CLI_OP_RET 4'hb
`define CLI_OP_CJMP 4'hc
`define CLI_CMD_STEP 28'h0000008
`define CLI_WIDE_STEP 28'h0000010
`define CLI_WORD_STEP 32'h00000004
`define CLI_PC_ALIGN 28'hffffff8
`define CLI_WORD_ALIGN 32'hfffffffc
`define CLI_MEM_ALIGN 32'h0ffffffc
`define CLI_REG_SPACE 32'h001ffffc
`endif

// ---- common/cli_pkg.sv ----
// types of the command list interpreter
package cli_pkg;
  typedef enum logic [2:0] {st_idle, st_fetch, st_exec, st_read, st_write, st_wait, st_next} cli_state_type;
  typedef struct packed {
    logic rd;
    logic wr;
    logic reg_space;
    logic [31:0] addr;
    logic [31:0] wdata;
  } cli_bus_req_type;
  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
  } cli_bus_rsp_type;
endpackage

// ---- verif/cli_mem_model.sv ----
// memory and register bus model facing the interpreter's bus master
`timescale 1ns/1ps
module cli_mem_model
  import cli_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // answer speed, one adds two wait cycles before each ack
  input wire logic slow_in,
  // bus from the interpreter
  input cli_bus_req_type req_in,
  output cli_bus_rsp_type rsp_out
);
  logic [31:0] mem [0:255];
  logic [31:0] regs [0:255];
  logic [1:0] wait_cnt;
  // plain always so the bench can preload mem; read data off ack is scrambled so a late sample fails
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      rsp_out <= '0;
      wait_cnt <= 2'h0;
    end else if ((req_in.rd || req_in.wr) && !rsp_out.ack && wait_cnt == (slow_in ? 2'h2 : 2'h0)) begin
      rsp_out.ack <= 1'b1;
      rsp_out.rdata <= req_in.reg_space ? regs[req_in.addr[9:2]] : mem[req_in.addr[9:2]];
      wait_cnt <= 2'h0;
      if (req_in.wr && req_in.reg_space) regs[req_in.addr[9:2]] <= req_in.wdata;
      else if (req_in.wr) mem[req_in.addr[9:2]] <= req_in.wdata;
    end else begin
      rsp_out.ack <= 1'b0;
      rsp_out.rdata <= ~rsp_out.rdata;
      wait_cnt <= ((req_in.rd || req_in.wr) && !rsp_out.ack) ? wait_cnt + 2'h1 : 2'h0;
    end
  end
endmodule

// ---- verif/command_list_interpreter_test.sv ----
// testbench of the command list interpreter
`timescale 1ns/1ps
`include "cli_defines.svh"
module command_list_interpreter_test;
  import cli_pkg::*;
  logic clk_in, rst_in, sw_wr_in, sw_rd_in, slow_in, irq_out;
  logic [7:0] sw_addr_in;
  logic [31:0] sw_wdata_in, sw_rdata_out, rd_val;
  logic [20:0] hw_status_in;
  logic [7:0] zr [0:4] = '{8'h1c, 8'h20, 8'h24, 8'h28, 8'h30};
  cli_bus_req_type bus_req_out;
  cli_bus_rsp_type bus_rsp_in;
  int err_total, checks_done;

  cli_interp i_cli_interp(.clk_in, .rst_in, .sw_addr_in, .sw_wdata_in, .sw_wr_in, .sw_rd_in, .sw_rdata_out,
    .bus_req_out, .bus_rsp_in, .hw_status_in, .irq_out);
  cli_mem_model i_cli_mem_model(.clk_in, .rst_in, .slow_in, .req_in(bus_req_out), .rsp_out(bus_rsp_in));

  initial begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    sw_wr_in <= 1'b1;
    sw_addr_in <= a;
    sw_wdata_in <= d;
    @(posedge clk_in);
    sw_wr_in <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge clk_in);
    sw_rd_in <= 1'b1;
    sw_addr_in <= a;
    @(posedge clk_in);
    sw_rd_in <= 1'b0;
    #1 rd_val = sw_rdata_out;
  endtask

  task automatic put(input logic [31:0] a, input logic [31:0] lo, input logic [31:0] hi);
    i_cli_mem_model.mem[a[9:2]] = lo;
    i_cli_mem_model.mem[a[9:2] + 8'h1] = hi;
  endtask

  task automatic wait_idle;
    int n;
    n = 0;
    rd(`CLI_REG_ADDR);
    while (rd_val[`CLI_IDLE_BIT] !== 1'b1 && n < 300) begin
      rd(`CLI_REG_ADDR);
      n++;
    end
    if (n >= 300) begin
      err_total++;
      $display("[ERR] idle wait expected 1 seen 0");
    end
  endtask

  task automatic report_and_stop;
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  initial begin
    #2000000;
    err_total++;
    $display("[ERR] watchdog expected done seen timeout");
    report_and_stop;
  end

  initial begin
    err_total = 0;
    checks_done = 0;
    sw_wr_in = 1'b0;
    sw_rd_in = 1'b0;
    sw_addr_in = 8'h00;
    sw_wdata_in = 32'h00000000;
    hw_status_in = 21'h000000;
    slow_in = 1'b1;
    rst_in = 1'b1;
    i_cli_mem_model.mem[8'hc0] = 32'h11111111;
    i_cli_mem_model.mem[8'hc1] = 32'h22222222;
    put(32'h100, {4'h4, 28'h0000202}, 32'h2);
    put(32'h108, 32'h00000302, 32'h0);
    put(32'h110, {4'h5, 28'h0000041}, 32'h2);
    put(32'h118, 32'h00000300, 32'h0);
    put(32'h120, {4'h6, 28'h0000003}, 32'h00000001);
    put(32'h128, {4'ha, 28'h0000180}, 32'h0);
    put(32'h130, {4'h9, 28'h0000015}, 32'h1);
    put(32'h138, {4'h8, 28'h0000001}, 32'h0);
    put(32'h140, {4'hc, 28'h0000010}, 32'h2);
    put(32'h148, {4'h8, 28'h0000001}, 32'h0);
    put(32'h150, {4'h8, 28'h0000001}, 32'h0);
    put(32'h158, {4'hf, 28'h0000000}, 32'h0);
    put(32'h160, {4'hc, 28'h0000010}, 32'h4);
    put(32'h168, {4'h8, 28'h0000001}, 32'h0);
    put(32'h180, {4'hb, 28'h0000000}, 32'h0);
    // third list: absolute goto, single loads, relative gosub, finish with the mask open
    put(32'h1c0, {4'h9, 28'h00001d3}, 32'h0);
    put(32'h1c8, {4'h8, 28'h0000000}, 32'h0);
    put(32'h1d0, {4'h1, 28'h0000062}, 32'h33333333);
    put(32'h1d8, {4'h0, 28'h0000285}, 32'h44444444);
    put(32'h1e0, {4'ha, 28'h0000060}, 32'h1);
    put(32'h1e8, {4'h8, 28'h0000001}, 32'h0);
    put(32'h1f0, {4'h9, 28'h00001f0}, 32'h0);
    put(32'h240, {4'hb, 28'h0000000}, 32'h0);
    repeat (10) @(posedge clk_in);
    rst_in <= 1'b0;
    rd(`CLI_REG_ADDR);
    check("addr_reset", rd_val, 32'h40000000);
    for (int i = 0; i < 5; i++) begin
      rd(zr[i]);
      check("reg_reset", rd_val, 32'h0);
    end
    wr(`CLI_REG_RET, 32'hffffffff);
    rd(`CLI_REG_RET);
    check("ret_readonly", rd_val, 32'h0);
    wr(`CLI_REG_COND, 32'h2);
    wr(`CLI_REG_ADDR, 32'h80000100);
    repeat (150) @(posedge clk_in);
    rd(`CLI_REG_ADDR);
    check("stall_addr", rd_val, 32'h80000120);
    hw_status_in <= 21'h000003;
    repeat (20) @(posedge clk_in);
    rd(`CLI_REG_RET);
    check("stall_masked", rd_val, 32'h0);
    hw_status_in <= 21'h000005;
    wait_idle;
    check("dst_word0", i_cli_mem_model.mem[8'h80], 32'h11111111);
    check("dst_word1", i_cli_mem_model.mem[8'h81], 32'h22222222);
    check("reg_word0", i_cli_mem_model.regs[8'h10], 32'h11111111);
    check("reg_word1", i_cli_mem_model.regs[8'h11], 32'h22222222);
    rd(`CLI_REG_RET);
    check("ret_saved", rd_val, 32'h00000130);
    rd(`CLI_REG_ADDR);
    check("end_addr", rd_val, 32'h40000168);
    rd(`CLI_REG_COND);
    check("cond_kept", rd_val, 32'h2);
    rd(`CLI_REG_ISTAT);
    check("irq_status", rd_val, 32'h1);
    check("irq_masked", {31'h0, irq_out}, 32'h0);
    wr(`CLI_REG_IMASK, 32'h1);
    #1 check("irq_on", {31'h0, irq_out}, 32'h1);
    wr(`CLI_REG_ISTAT, 32'h1);
    #1 check("irq_off", {31'h0, irq_out}, 32'h0);
    slow_in <= 1'b0;
    hw_status_in <= 21'h000000;
    wr(`CLI_REG_ADDR, 32'h80000120);
    repeat (30) @(posedge clk_in);
    rd(`CLI_REG_ADDR);
    check("wait_again", rd_val, 32'h80000120);
    wr(`CLI_REG_ADDR, 32'h0);
    wait_idle;
    rd(`CLI_REG_ADDR);
    check("stop_addr", rd_val, 32'h40000120);
    wr(`CLI_REG_ADDR, 32'h800001c0);
    wait_idle;
    check("ldreg_word", i_cli_mem_model.regs[8'h18], 32'h33333333);
    check("ldmem_word", i_cli_mem_model.mem[8'ha1], 32'h44444444);
    rd(`CLI_REG_RET);
    check("ret_rel", rd_val, 32'h000001e8);
    rd(`CLI_REG_ADDR);
    check("end_addr2", rd_val, 32'h400001e8);
    check("irq_open", {31'h0, irq_out}, 32'h1);
    // a list that loops on itself only ends by clearing start
    wr(`CLI_REG_ADDR, 32'h800001f0);
    repeat (25) @(posedge clk_in);
    wr(`CLI_REG_ADDR, 32'h0);
    wait_idle;
    rd(`CLI_REG_ADDR);
    check("loop_stop", rd_val, 32'h400001f0);
    report_and_stop;
  end
endmodule
